// >>> wwd_consts.svh
// Offsets, field positions, reset values and timing counts of the windowed watchdog
`ifndef WWD_CONSTS_SVH
`define WWD_CONSTS_SVH

`define WWD_AW            12
`define WWD_ADDR_CTRL0    12'h000
`define WWD_ADDR_CTRL1    12'h004
`define WWD_ADDR_POWER_CONTROL_0    12'h008
`define WWD_ADDR_COUNT    12'h00c
`define WWD_ADDR_IRQ_ST   12'h010
`define WWD_ADDR_IRQ_EN   12'h014
`define WWD_ADDR_IRQ_CLR  12'h018

`define WWD_C0_EN_BIT     0
`define WWD_C0_PS_LSB     1
`define WWD_C0_PS_MSB     5
`define WWD_C1_CS_LSB     0
`define WWD_C1_CS_MSB     2
`define WWD_C1_WIN_LSB    8
`define WWD_C1_WIN_MSB    10
`define WWD_PC_WV_BIT     0
`define WWD_EV_TIMEOUT    0
`define WWD_EV_VIOLATION  1
`define WWD_NUM_EV        2

`define WWD_EN_RST        1'b0
`define WWD_PS_RST        5'h0b
`define WWD_CS_RST        3'h0
`define WWD_WIN_RST       3'h7
`define WWD_EV_RST        2'h0

`define WWD_CFG_SW_PS     5'h1f
`define WWD_CFG_SW_WIN    3'h7
`define WWD_CFG_SW_CS     3'h7
`define WWD_PS_MAX        5'h12
`define WWD_WIN_FULL      3'h7

`define WWD_MODE_ON       2'h3
`define WWD_MODE_NOSLEEP  2'h2
`define WWD_MODE_SW       2'h1

`define WWD_MS_US         1000
`define WWD_LF_HZ         31000
`define WWD_MF_HZ         31250
`define WWD_LF_TICKS      ((`WWD_LF_HZ * `WWD_MS_US + 999999) / 1000000)
`define WWD_MF_TICKS      ((`WWD_MF_HZ * `WWD_MS_US + 999999) / 1000000)

`endif

// >>> wwd_pkg.sv
// Types shared by the windowed watchdog files
package wwd_pkg;
  typedef enum logic [0:0] {
    WWD_DISARMED = 1'b0,
    WWD_ARMED    = 1'b1
  } wwd_arm_t;

  typedef enum logic [0:0] {
    WWD_SRC_LF = 1'b0,
    WWD_SRC_MF = 1'b1
  } wwd_src_t;
endpackage : wwd_pkg

// >>> wwd_sync.sv
// Two-flop synchroniser for inputs from other clock domains
`timescale 1ns/1ps
`default_nettype none
module wwd_sync #(
  parameter int W = 2
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (!rst_b) begin
          meta[i]     <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule : wwd_sync
`default_nettype wire

// >>> wwd_top.sv
// Windowed watchdog timer with APB registers and interrupt
// What this block does
// - With the period config field at all ones, the period comes from the software field.
// - Any other period config value sets the period and the software field is ignored.
// - After any reset the period defaults to about two seconds.
// - A clear instruction while the window is closed is a violation and resets.
// - Window size comes from the config field unless it is 111, then from control 1.
// - Window open is decided from the upper five bits of the count.
// - A violation raises a reset and clears the violation flag.
// - Power-on reset sets the violation flag and software may also write it.
// - The count clears on reset, valid clear, violation, timeout, sleep in/out, disable, startup timer, writes to control 0 or 1.
// - In windowed mode only a clear armed by a read of control 0, with the window open, clears the timer without a violation.
// - In windowed mode an unarmed clear instruction is a violation whether the window is open or not.
// - The time base is the low or mid frequency oscillator, chosen by config or software.
// - Enable config 11 on, 10 on except sleep, 01 by software bit, 00 off.
`include "wwd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module wwd_top (
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                power_on_reset,
  input  wire logic [`WWD_AW-1:0]  paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  input  wire logic [4:0]          period_config_field,
  input  wire logic [2:0]          window_config_field,
  input  wire logic [2:0]          clock_config_field,
  input  wire logic [1:0]          wd_enable_config,
  input  wire logic                watchdog_clear_instruction,
  input  wire logic                sleeping,
  input  wire logic                sleep_entry,
  input  wire logic                sleep_exit_irq,
  input  wire logic                oscillator_startup_timer,
  input  wire logic                low_freq_internal_osc,
  input  wire logic                mid_freq_internal_osc,
  output var  logic                wd_reset,
  output var  logic                window_violation_flag,
  output var  logic                irq
);
  // Control register fields
  logic                       software_enable_bit;
  logic [4:0]                 period_select_field;
  logic [2:0]                 sw_clock_select;
  logic [2:0]                 sw_window_field;
  logic [`WWD_NUM_EV-1:0]     irq_status;
  logic [`WWD_NUM_EV-1:0]     irq_enable;
  wwd_pkg::wwd_arm_t          arm_state;

  // Time base
  logic [1:0]                 osc_sync;
  logic [1:0]                 osc_prev;
  logic                       tick;
  logic [5:0]                 prescale;
  logic [5:0]                 ticks_per_ms;
  wwd_pkg::wwd_src_t          src;

  // Counter and window
  logic [18:0]                wd_timer_count;
  logic [4:0]                 eff_ps;
  logic [2:0]                 eff_win;
  logic [2:0]                 eff_cs;
  logic [18:0]                period_ms;
  logic [23:0]                count_ext;
  logic [4:0]                 frac5;
  logic [4:0]                 open_thresh;
  logic                       window_open;
  logic                       windowed;
  logic                       active;
  logic                       timeout;
  logic                       clr_attempt;
  logic                       valid_clear;
  logic                       violation;
  logic                       count_clear;

  // Bus decode
  logic                       acc;
  logic                       wr;
  logic                       rd;
  logic                       hit;
  logic [31:0]                rd_mux;

  wwd_sync #(.W(2)) u_osc_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in ({mid_freq_internal_osc, low_freq_internal_osc}),
    .sync_out (osc_sync)
  );

  // Edge detect only on synchronised levels
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      osc_prev <= 2'h0;
    end else begin
      osc_prev <= osc_sync;
    end
  end

  // Software field takes over only when config is left blank
  always_comb begin
    eff_cs = (clock_config_field == `WWD_CFG_SW_CS) ? sw_clock_select
                                                     : clock_config_field;
    src    = (eff_cs[0]) ? wwd_pkg::WWD_SRC_MF : wwd_pkg::WWD_SRC_LF;
    unique case (src)
      wwd_pkg::WWD_SRC_LF: begin
        tick         = osc_sync[0] & ~osc_prev[0];
        ticks_per_ms = 6'(`WWD_LF_TICKS);
      end
      wwd_pkg::WWD_SRC_MF: begin
        tick         = osc_sync[1] & ~osc_prev[1];
        ticks_per_ms = 6'(`WWD_MF_TICKS);
      end
    endcase
  end

  always_comb begin
    if (period_config_field == `WWD_CFG_SW_PS) begin
      eff_ps = period_select_field;
    end else begin
      eff_ps = period_config_field;
    end
    if (eff_ps > `WWD_PS_MAX) begin
      eff_ps = `WWD_PS_MAX;
    end
  end

  always_comb begin
    eff_win = (window_config_field == `WWD_CFG_SW_WIN) ? sw_window_field
                                                        : window_config_field;
    windowed    = (eff_win != `WWD_WIN_FULL);
    // Open share is (win+1)/8 of the period, at its end
    open_thresh = 5'h1c - {eff_win, 2'b00};
    period_ms   = 19'h00001 << eff_ps;
    count_ext   = {wd_timer_count, 5'h00};
    frac5       = 5'(count_ext >> eff_ps);
    window_open = (frac5 >= open_thresh);
  end

  always_comb begin
    unique case (wd_enable_config)
      `WWD_MODE_ON:      active = 1'b1;
      `WWD_MODE_NOSLEEP: active = ~sleeping;
      `WWD_MODE_SW:      active = software_enable_bit;
      default:           active = 1'b0;
    endcase
  end

  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;

  always_comb begin
    clr_attempt = watchdog_clear_instruction & active;
    // Unarmed clear is a violation even with the window open
    violation   = clr_attempt & windowed &
                  ((arm_state != wwd_pkg::WWD_ARMED) | ~window_open);
    valid_clear = clr_attempt & ~violation;
    timeout     = active & tick & (wd_timer_count + 19'h00001 >= period_ms) &
                  (prescale == ticks_per_ms - 6'h01);
    count_clear = valid_clear | violation | timeout | sleep_entry | sleep_exit_irq |
                  ~active | oscillator_startup_timer |
                  (wr & ((paddr == `WWD_ADDR_CTRL0) | (paddr == `WWD_ADDR_CTRL1)));
  end

  // Counting in whole milliseconds keeps the window compare a shift
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prescale       <= 6'h00;
      wd_timer_count <= 19'h00000;
    end else if (count_clear) begin
      prescale       <= 6'h00;
      wd_timer_count <= 19'h00000;
    end else if (tick) begin
      if (prescale >= ticks_per_ms - 6'h01) begin
        prescale       <= 6'h00;
        wd_timer_count <= wd_timer_count + 19'h00001;
      end else begin
        prescale <= prescale + 6'h01;
      end
    end
  end

  // Arming: a read of control 0 arms, any clear instruction spends it, even while inactive
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      arm_state <= wwd_pkg::WWD_DISARMED;
    end else begin
      unique case (arm_state)
        wwd_pkg::WWD_DISARMED: begin
          if (rd & (paddr == `WWD_ADDR_CTRL0) & ~watchdog_clear_instruction) begin
            arm_state <= wwd_pkg::WWD_ARMED;
          end
        end
        wwd_pkg::WWD_ARMED: begin
          if (watchdog_clear_instruction) begin
            arm_state <= wwd_pkg::WWD_DISARMED;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wd_reset <= 1'b0;
    end else begin
      wd_reset <= violation | timeout;
    end
  end

  // Flag survives ordinary resets; only power-on sets it during reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      if (power_on_reset) begin
        window_violation_flag <= 1'b1;
      end
    end else if (violation) begin
      window_violation_flag <= 1'b0;
    end else if (wr & (paddr == `WWD_ADDR_POWER_CONTROL_0)) begin
      window_violation_flag <= pwdata[`WWD_PC_WV_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      software_enable_bit <= `WWD_EN_RST;
      period_select_field <= `WWD_PS_RST;
    end else if (wr & (paddr == `WWD_ADDR_CTRL0)) begin
      software_enable_bit <= pwdata[`WWD_C0_EN_BIT];
      period_select_field <= pwdata[`WWD_C0_PS_MSB:`WWD_C0_PS_LSB];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sw_clock_select <= `WWD_CS_RST;
      sw_window_field <= `WWD_WIN_RST;
    end else if (wr & (paddr == `WWD_ADDR_CTRL1)) begin
      sw_clock_select <= pwdata[`WWD_C1_CS_MSB:`WWD_C1_CS_LSB];
      sw_window_field <= pwdata[`WWD_C1_WIN_MSB:`WWD_C1_WIN_LSB];
    end
  end

  // Status: a new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_status <= `WWD_EV_RST;
    end else begin
      irq_status <= (irq_status &
                     ~((wr & (paddr == `WWD_ADDR_IRQ_CLR)) ?
                       pwdata[`WWD_NUM_EV-1:0] : `WWD_EV_RST)) |
                    {violation, timeout};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_enable <= `WWD_EV_RST;
    end else if (wr & (paddr == `WWD_ADDR_IRQ_EN)) begin
      irq_enable <= pwdata[`WWD_NUM_EV-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h00000000;
    unique case (paddr)
      `WWD_ADDR_CTRL0: begin
        rd_mux[`WWD_C0_EN_BIT]                  = software_enable_bit;
        rd_mux[`WWD_C0_PS_MSB:`WWD_C0_PS_LSB]   = period_select_field;
      end
      `WWD_ADDR_CTRL1: begin
        rd_mux[`WWD_C1_CS_MSB:`WWD_C1_CS_LSB]   = sw_clock_select;
        rd_mux[`WWD_C1_WIN_MSB:`WWD_C1_WIN_LSB] = sw_window_field;
      end
      `WWD_ADDR_POWER_CONTROL_0:  rd_mux[`WWD_PC_WV_BIT] = window_violation_flag;
      `WWD_ADDR_COUNT:  rd_mux[18:0] = wd_timer_count;
      `WWD_ADDR_IRQ_ST: rd_mux[`WWD_NUM_EV-1:0] = irq_status;
      `WWD_ADDR_IRQ_EN: rd_mux[`WWD_NUM_EV-1:0] = irq_enable;
      `WWD_ADDR_IRQ_CLR: rd_mux = 32'h00000000;
      default:          hit = 1'b0;
    endcase
  end

  // One cycle of setup, answer in the first access cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel & ~penable & ~pready) begin
      pready  <= 1'b1;
      pslverr <= ~hit;
      prdata  <= (pwrite | ~hit) ? 32'h00000000 : rd_mux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
  end
endmodule : wwd_top
`default_nettype wire

// >>> wwd_chk.sv
// Port-level assertions for the windowed watchdog
`include "wwd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module wwd_chk (
  input wire logic               clock,
  input wire logic               rst_b,
  input wire logic               power_on_reset,
  input wire logic [`WWD_AW-1:0] paddr,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [2:0]         window_config_field,
  input wire logic [1:0]         wd_enable_config,
  input wire logic               watchdog_clear_instruction,
  input wire logic               wd_reset,
  input wire logic               window_violation_flag,
  input wire logic               irq
);
  default clocking cb @(posedge clock); endclocking
  logic armed;
  // Arm mirror; any clear spends it, even while inactive
  always_ff @(posedge clock) begin
    if (!rst_b)
      armed <= 1'b0;
    else if (watchdog_clear_instruction)
      armed <= 1'b0;
    else if (psel && penable && pready && !pwrite && paddr == `WWD_ADDR_CTRL0)
      armed <= 1'b1;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad_clear;
    wd_enable_config == 2'h3 && window_config_field != 3'h7 && watchdog_clear_instruction && !armed;
  endsequence
  sequence s_off;
    (wd_enable_config == 2'h0) [*2];
  endsequence
  a_setup_ready: assert property (disable iff (!rst_b) s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (disable iff (!rst_b) pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (disable iff (!rst_b) pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (disable iff (!rst_b) !pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  a_unmapped_err: assert property (disable iff (!rst_b) s_setup and paddr == 12'h020 |=> pslverr)
    else $error("no error on unmapped address");
  a_wdr_pulse: assert property (disable iff (!rst_b) wd_reset |=> !wd_reset)
    else $error("watchdog reset longer than one cycle");
  a_bad_clear: assert property (disable iff (!rst_b) s_bad_clear |=> wd_reset && !window_violation_flag)
    else $error("unarmed clear did not violate");
  a_off_quiet: assert property (disable iff (!rst_b) s_off |=> !wd_reset)
    else $error("watchdog reset while disabled");
  a_flag_por: assert property (!rst_b && power_on_reset |=> window_violation_flag)
    else $error("flag not set by power-on");
  a_rst_quiet: assert property (!rst_b |=> !wd_reset && !irq && !pready)
    else $error("outputs active after reset");
endmodule : wwd_chk
bind wwd_top wwd_chk u_chk (.clock, .rst_b, .power_on_reset, .paddr, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .window_config_field, .wd_enable_config,
  .watchdog_clear_instruction, .wd_reset, .window_violation_flag, .irq);
`default_nettype wire

// >>> wwd_core_model.sv
// Core-side model issuing one-cycle clear instructions
`timescale 1ns/1ps
`default_nettype none
module wwd_core (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic fire,
  output var  logic clear_pulse
);
  logic fire_q;
  // Toggle request, so clears may follow each other closely
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      fire_q      <= 1'b0;
      clear_pulse <= 1'b0;
    end else begin
      fire_q      <= fire;
      clear_pulse <= fire != fire_q;
    end
  end
endmodule : wwd_core
`default_nettype wire

// >>> wwd_top_tb.sv
// Self-checking bench for the windowed watchdog
`include "wwd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module wwd_top_tb;
  logic        clock, rst_b, por, psel, penable, pwrite, pready, pslverr, e;
  logic        sleeping, osc, fire, clr, wd_reset, flag, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic [4:0]  period_cfg;
  logic [2:0]  window_cfg;
  logic [1:0]  mode;
  int          n_fail, n_compared, seed;
  logic [31:0] mdl [int];
  wwd_top u_dut (.clock(clock), .rst_b(rst_b), .power_on_reset(por), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .period_config_field(period_cfg),
    .window_config_field(window_cfg), .clock_config_field(3'h0), .wd_enable_config(mode),
    .watchdog_clear_instruction(clr), .sleeping(sleeping), .sleep_entry(1'b0),
    .sleep_exit_irq(1'b0), .oscillator_startup_timer(1'b0), .low_freq_internal_osc(osc),
    .mid_freq_internal_osc(osc), .wd_reset(wd_reset), .window_violation_flag(flag), .irq(irq));
  wwd_core u_core (.clock(clock), .rst_b(rst_b), .fire(fire), .clear_pulse(clr));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Slow oscillator, 8 clocks a period, phase unrelated
  initial begin
    osc = 1'b0;
    #7;
    forever #80 osc = ~osc;
  end
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    mdl[a] = d;
  endtask : wr
  task automatic rd(input string nm, input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    chk(nm, mdl[a], r);
  endtask : rd
  task automatic wait_wd(input int lim, input logic ex);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < lim && !seen; n++) begin
      @(posedge clock);
      #1 seen = (wd_reset === 1'b1);
    end
    chk("wd_reset", {31'h0, ex}, {31'h0, seen});
    if (ex && !seen)
      print_verdict();
  endtask : wait_wd
  task automatic clear_once();
    @(posedge clock);
    fire <= ~fire;
  endtask : clear_once
  task automatic irq_is(input logic ex);
    repeat (2) @(posedge clock);
    #1 chk("irq", {31'h0, ex}, {31'h0, irq});
  endtask : irq_is
  initial begin
    {rst_b, psel, penable, pwrite, sleeping, fire, paddr, pwdata} = '0;
    {por, period_cfg, window_cfg, mode} = {1'b1, 5'h1f, 3'h7, 2'h0};
    n_fail = 0;
    n_compared = 0;
    seed = $urandom(32'h4b6e);
    mdl[`WWD_ADDR_CTRL0] = 32'h16;
    mdl[`WWD_ADDR_CTRL1] = 32'h700;
    mdl[`WWD_ADDR_POWER_CONTROL_0] = 32'h1;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    por <= 1'b0;
    rd("ctrl0", `WWD_ADDR_CTRL0);
    rd("ctrl1", `WWD_ADDR_CTRL1);
    rd("flag", `WWD_ADDR_POWER_CONTROL_0);
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    repeat (4) begin
      v = $urandom & 32'h3e;
      wr(`WWD_ADDR_CTRL0, v);
      rd("ctrl0_rw", `WWD_ADDR_CTRL0);
    end
    period_cfg <= 5'h00;
    wr(`WWD_ADDR_IRQ_EN, 32'h3);
    for (int m = 0; m < 4; m++) begin
      mode <= m[1:0];
      wr(`WWD_ADDR_CTRL0, 32'h1);
      wait_wd(400, m != 0);
      apb(1'b0, `WWD_ADDR_IRQ_ST, 32'h0);
      chk("status", {31'h0, m != 0}, r);
      chk("irq", {31'h0, m != 0}, {31'h0, irq});
      wr(`WWD_ADDR_IRQ_CLR, 32'h3);
    end
    mode <= 2'h2;
    sleeping <= 1'b1;
    wr(`WWD_ADDR_CTRL0, 32'h0);
    wait_wd(400, 1'b0);
    sleeping <= 1'b0;
    period_cfg <= 5'h1f;
    mode <= 2'h1;
    wr(`WWD_ADDR_CTRL0, 32'h3);
    wait_wd(400, 1'b0);
    wait_wd(300, 1'b1);
    // Two-ms period so the count reaches one and the open half is visible
    period_cfg <= 5'h01;
    mode <= 2'h3;
    wr(`WWD_ADDR_CTRL0, 32'h1);
    clear_once();
    wait_wd(3, 1'b0);
    window_cfg <= 3'h3;
    clear_once();
    wait_wd(3, 1'b1);
    chk("flag_pin", 32'h0, {31'h0, flag});
    mdl[`WWD_ADDR_POWER_CONTROL_0] = 32'h0;
    rd("flag_low", `WWD_ADDR_POWER_CONTROL_0);
    wr(`WWD_ADDR_POWER_CONTROL_0, 32'h1);
    rd("flag_set", `WWD_ADDR_POWER_CONTROL_0);
    rd("arm", `WWD_ADDR_CTRL0);
    clear_once();
    wait_wd(3, 1'b1);
    repeat (300) @(posedge clock);
    rd("arm", `WWD_ADDR_CTRL0);
    clear_once();
    wait_wd(3, 1'b0);
    wait_wd(200, 1'b0);
    window_cfg <= 3'h7;
    wr(`WWD_ADDR_CTRL1, 32'h0);
    rd("arm", `WWD_ADDR_CTRL0);
    clear_once();
    wait_wd(3, 1'b1);
    wr(`WWD_ADDR_IRQ_EN, 32'h0);
    irq_is(1'b0);
    wr(`WWD_ADDR_IRQ_EN, 32'h2);
    irq_is(1'b1);
    wr(`WWD_ADDR_IRQ_CLR, 32'h2);
    irq_is(1'b0);
    print_verdict();
  end
endmodule : wwd_top_tb
`default_nettype wire
